// ===== cdd_clock_dividers.sv
// Clock distribution dividers: source select, prescaler, channel dividers and register port.
`timescale 1ns/1ps
`default_nettype none

module cdd_div_stage (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Divider input clock level and settings.
  input wire logic in_lvl,
  input wire logic [3:0] low_cnt,
  input wire logic [3:0] high_cnt,
  input wire logic bypass,
  input wire logic dcc_on,
  // Divided clock level.
  output logic out_lvl
);

  logic prev_r;
  logic prev_nxt;
  logic out_r;
  logic out_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic in_rise;
  logic in_fall;
  logic step;
  logic [4:0] full_m1;

  // Edges of the input clock; correction counts both edges, plain division only rising ones.
  assign in_rise = in_lvl & ~prev_r;
  assign in_fall = ~in_lvl & prev_r;
  assign step = dcc_on ? (in_rise | in_fall) : in_rise;
  assign full_m1 = 5'({1'b0, high_cnt} + {1'b0, low_cnt} + 5'h01);
  assign out_lvl = out_r;

  // Next phase and count of the divider.
  always_comb
  begin
    prev_nxt = in_lvl;
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    if (bypass)
    begin
      out_nxt = in_lvl;
      cnt_nxt = '0;
    end
    else if (step)
    begin
      if (cnt_r == 5'h00)
      begin
        out_nxt = ~out_r;
        if (dcc_on)
          cnt_nxt = full_m1;
        else if (out_r)
          cnt_nxt = {1'b0, low_cnt};
        else
          cnt_nxt = {1'b0, high_cnt};
      end
      else
        cnt_nxt = cnt_r - 5'h01;
    end
  end

  // Divider state registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_r <= 1'b0;
      out_r <= 1'b0;
      cnt_r <= 5'h00;
    end
    else
    begin
      prev_r <= prev_nxt;
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // A high phase starts with the high count loaded.
  property p_high_load;
    @(posedge clk) disable iff (!resetn)
    ($rose(out_r) && $past(!bypass && !dcc_on)) |-> cnt_r == {1'b0, $past(high_cnt)};
  endproperty
  a_high_load: assert property (p_high_load) else $error("high phase length wrong");

  // A low phase starts with the low count loaded.
  property p_low_load;
    @(posedge clk) disable iff (!resetn)
    ($fell(out_r) && $past(!bypass && !dcc_on)) |-> cnt_r == {1'b0, $past(low_cnt)};
  endproperty
  a_low_load: assert property (p_low_load) else $error("low phase length wrong");

  // With correction, each phase lasts the full ratio in input edges.
  property p_dcc_load;
    @(posedge clk) disable iff (!resetn)
    ($changed(out_r) && $past(!bypass && dcc_on)) |-> cnt_r == $past(full_m1);
  endproperty
  a_dcc_load: assert property (p_dcc_load) else $error("corrected phase wrong");

  // Bypass copies the input one cycle later and parks the counter.
  property p_bypass;
    @(posedge clk) disable iff (!resetn)
    $past(bypass) |-> (out_r == $past(in_lvl)) && (cnt_r == 5'h00);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not copy input");

  // Plain division only advances on a rising input edge.
  property p_count_input;
    @(posedge clk) disable iff (!resetn)
    ($changed(cnt_r) && $past(!bypass && !dcc_on)) |-> $past(in_lvl && !prev_r);
  endproperty
  a_count_input: assert property (p_count_input) else $error("count without input edge");

endmodule

module cdd_clock_dividers (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Source clock levels.
  input wire logic ext_clk_in,
  input wire logic osc_clk_in,
  // Single-stage output pairs.
  output logic pair0_out_a,
  output logic pair0_out_b,
  output logic pair1_out_a,
  output logic pair1_out_b,
  output logic pair2_out_a,
  output logic pair2_out_b,
  // Cascaded output pairs.
  output logic pair3_out_a,
  output logic pair3_out_b,
  output logic pair4_out_a,
  output logic pair4_out_b
);

  // Maps an address to {hit, storage index}.
  function automatic logic [5:0] reg_decode(input logic [9:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a == cdd_pkg::OFS_CH0_COUNTS) r = 6'h20;
    else if (a == cdd_pkg::OFS_CH0_BYPASS) r = 6'h21;
    else if (a == cdd_pkg::OFS_CH0_ROUTE) r = 6'h22;
    else if (a == cdd_pkg::OFS_CH1_COUNTS) r = 6'h23;
    else if (a == cdd_pkg::OFS_CH1_BYPASS) r = 6'h24;
    else if (a == cdd_pkg::OFS_CH1_ROUTE) r = 6'h25;
    else if (a == cdd_pkg::OFS_CH2_COUNTS) r = 6'h26;
    else if (a == cdd_pkg::OFS_CH2_BYPASS) r = 6'h27;
    else if (a == cdd_pkg::OFS_CH2_ROUTE) r = 6'h28;
    else if (a == cdd_pkg::OFS_PRESCALER) r = 6'h29;
    else if (a == cdd_pkg::OFS_SOURCE) r = 6'h2a;
    else if (a == cdd_pkg::OFS_CH3_S1_COUNTS) r = 6'h2b;
    else if (a == cdd_pkg::OFS_CH3_S2_COUNTS) r = 6'h2c;
    else if (a == cdd_pkg::OFS_CH3_BYPASS) r = 6'h2d;
    else if (a == cdd_pkg::OFS_CH3_DUTY) r = 6'h2e;
    else if (a == cdd_pkg::OFS_CH4_S1_COUNTS) r = 6'h2f;
    else if (a == cdd_pkg::OFS_CH4_S2_COUNTS) r = 6'h30;
    else if (a == cdd_pkg::OFS_CH4_BYPASS) r = 6'h31;
    else if (a == cdd_pkg::OFS_CH4_DUTY) r = 6'h32;
    return r;
  endfunction

  // Clamps the prescaler field to a ratio of 2 to 6.
  function automatic logic [2:0] presc_ratio(input logic [2:0] f);
    logic [2:0] r;
    r = f;
    if (f < cdd_pkg::PRESC_MIN) r = cdd_pkg::PRESC_MIN;
    else if (f > cdd_pkg::PRESC_MAX) r = cdd_pkg::PRESC_MAX;
    return r;
  endfunction

  logic [7:0] reg_r [cdd_pkg::NREG];
  logic [7:0] reg_nxt [cdd_pkg::NREG];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [5:0] dec;
  logic [7:0] status;
  logic [1:0] src_code;
  logic src_bad;
  logic use_ps;
  logic src_lvl;
  logic src_prev_r;
  logic src_rise;
  logic src_edge;
  logic [2:0] ps_ratio;
  logic [2:0] ps_cnt_r;
  logic [2:0] ps_cnt_nxt;
  logic [2:0] ps_edge_r;
  logic [2:0] ps_edge_nxt;
  logic ps_raw_r;
  logic ps_raw_nxt;
  logic ps_cor_r;
  logic ps_cor_nxt;
  logic [4:0] stage_out;
  logic [2:0] direct;
  logic [4:0] pair_r;
  logic [4:0] pair_nxt;

  assign dec = reg_decode(reg_addr);
  assign status = {1'b0, use_ps, src_bad, pair_r};

  // Register writes and the one-cycle-late read answer.
  always_comb
  begin
    for (int k = 0; k < cdd_pkg::NREG; k++)
      reg_nxt[k] = reg_r[k];
    rdata_nxt = 8'h00;
    if (reg_wr && dec[5])
      reg_nxt[dec[4:0]] = reg_wdata;
    if (reg_rd)
    begin
      if (dec[5])
        rdata_nxt = reg_r[dec[4:0]];
      else if (reg_addr == cdd_pkg::OFS_STATUS)
        rdata_nxt = status;
    end
  end

  // Register storage; duty correction disable bits reset to zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < cdd_pkg::NREG; k++)
        reg_r[k] <= cdd_pkg::RST_OTHER;
      reg_r[cdd_pkg::IDX_PRESCALER] <= cdd_pkg::RST_PRESCALER;
      reg_r[cdd_pkg::IDX_SOURCE] <= cdd_pkg::RST_SOURCE;
      rdata_r <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < cdd_pkg::NREG; k++)
        reg_r[k] <= reg_nxt[k];
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Source select: external or oscillator through the prescaler, or external alone.
  assign src_code = reg_r[cdd_pkg::IDX_SOURCE][1:0];
  assign src_bad = (src_code == cdd_pkg::SRC_BAD);
  assign use_ps = (src_code == cdd_pkg::SRC_EXT_PS) || (src_code == cdd_pkg::SRC_OSC_PS);
  assign src_lvl = (src_code == cdd_pkg::SRC_OSC_PS) ? osc_clk_in : ext_clk_in;
  assign src_rise = src_lvl & ~src_prev_r;
  assign src_edge = src_lvl ^ src_prev_r;
  assign ps_ratio = presc_ratio(reg_r[cdd_pkg::IDX_PRESCALER][2:0]);

  // Prescaler: a rising-edge counter gives the raw output, a both-edge counter the corrected one.
  always_comb
  begin
    ps_cnt_nxt = ps_cnt_r;
    ps_edge_nxt = ps_edge_r;
    ps_raw_nxt = ps_raw_r;
    ps_cor_nxt = ps_cor_r;
    if (use_ps && src_rise)
    begin
      if (ps_cnt_r >= ps_ratio - 3'h1)
        ps_cnt_nxt = 3'h0;
      else
        ps_cnt_nxt = ps_cnt_r + 3'h1;
      ps_raw_nxt = (ps_cnt_nxt < (ps_ratio >> 1));
    end
    if (use_ps && src_edge)
    begin
      if (ps_edge_r >= ps_ratio - 3'h1)
      begin
        ps_edge_nxt = 3'h0;
        ps_cor_nxt = ~ps_cor_r;
      end
      else
        ps_edge_nxt = ps_edge_r + 3'h1;
    end
  end

  // Prescaler registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_prev_r <= 1'b0;
      ps_cnt_r <= 3'h0;
      ps_edge_r <= 3'h0;
      ps_raw_r <= 1'b0;
      ps_cor_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= src_lvl;
      ps_cnt_r <= ps_cnt_nxt;
      ps_edge_r <= ps_edge_nxt;
      ps_raw_r <= ps_raw_nxt;
      ps_cor_r <= ps_cor_nxt;
    end
  end

  // Single-stage channels; a bypassed and corrected channel takes the corrected prescaler output.
  for (genvar gi = 0; gi < 3; gi++)
  begin : g_single
    localparam int B = cdd_pkg::IDX_CH0_COUNTS + cdd_pkg::SINGLE_STRIDE * gi;
    logic byp;
    logic dcc_on;
    logic ch_in;
    assign byp = reg_r[B + 1][cdd_pkg::BIT_BYPASS];
    assign dcc_on = ~reg_r[B + 2][cdd_pkg::BIT_DUTY_OFF];
    assign direct[gi] = reg_r[B + 2][cdd_pkg::BIT_DIRECT];
    assign ch_in = src_bad ? 1'b0 : !use_ps ? src_lvl : (byp && dcc_on) ? ps_cor_r : ps_raw_r;
    cdd_div_stage u_stage (
      .clk(clk),
      .resetn(resetn),
      .in_lvl(ch_in),
      .low_cnt(reg_r[B][cdd_pkg::LOW_MSB:cdd_pkg::LOW_LSB]),
      .high_cnt(reg_r[B][cdd_pkg::HIGH_MSB:cdd_pkg::HIGH_LSB]),
      .bypass(byp),
      .dcc_on(dcc_on),
      .out_lvl(stage_out[gi])
    );
  end

  // Cascaded channels; the second stage divides the first stage's output.
  for (genvar gj = 0; gj < 2; gj++)
  begin : g_cascade
    localparam int B = cdd_pkg::IDX_CH3_S1 + cdd_pkg::CASC_STRIDE * gj;
    logic byp1;
    logic byp2;
    logic dcc_on;
    logic ch_in;
    logic mid;
    assign byp1 = reg_r[B + 2][cdd_pkg::BIT_BYP_S1];
    assign byp2 = reg_r[B + 2][cdd_pkg::BIT_BYP_S2];
    assign dcc_on = ~reg_r[B + 3][cdd_pkg::BIT_DUTY_OFF];
    assign ch_in = src_bad ? 1'b0 : !use_ps ? src_lvl
                 : (byp1 && byp2 && dcc_on) ? ps_cor_r : ps_raw_r;
    cdd_div_stage u_first (
      .clk(clk),
      .resetn(resetn),
      .in_lvl(ch_in),
      .low_cnt(reg_r[B][cdd_pkg::LOW_MSB:cdd_pkg::LOW_LSB]),
      .high_cnt(reg_r[B][cdd_pkg::HIGH_MSB:cdd_pkg::HIGH_LSB]),
      .bypass(byp1),
      .dcc_on(dcc_on),
      .out_lvl(mid)
    );
    cdd_div_stage u_second (
      .clk(clk),
      .resetn(resetn),
      .in_lvl(mid),
      .low_cnt(reg_r[B + 1][cdd_pkg::LOW_MSB:cdd_pkg::LOW_LSB]),
      .high_cnt(reg_r[B + 1][cdd_pkg::HIGH_MSB:cdd_pkg::HIGH_LSB]),
      .bypass(byp2),
      .dcc_on(dcc_on),
      .out_lvl(stage_out[3 + gj])
    );
  end

  // Output drivers: direct routing on pairs 0 to 2 skips prescaler and divider while the prescaler is in use, a forbidden source holds low.
  always_comb
  begin
    for (int k = 0; k < 5; k++)
      pair_nxt[k] = src_bad ? 1'b0 : stage_out[k];
    for (int k = 0; k < 3; k++)
      if (!src_bad && use_ps && direct[k])
        pair_nxt[k] = src_lvl;
  end

  // Output pair registers; the second leg is the complement.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pair_r <= 5'h00;
    else
      pair_r <= pair_nxt;
  end

  logic [4:0] pair_n_r;

  // Complement legs registered alongside the true legs.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pair_n_r <= 5'h1f;
    else
      pair_n_r <= ~pair_nxt;
  end

  assign pair0_out_a = pair_r[0];
  assign pair0_out_b = pair_n_r[0];
  assign pair1_out_a = pair_r[1];
  assign pair1_out_b = pair_n_r[1];
  assign pair2_out_a = pair_r[2];
  assign pair2_out_b = pair_n_r[2];
  assign pair3_out_a = pair_r[3];
  assign pair3_out_b = pair_n_r[3];
  assign pair4_out_a = pair_r[4];
  assign pair4_out_b = pair_n_r[4];

  // Direct routing copies the selected source one cycle later.
  property p_direct;
    @(posedge clk) disable iff (!resetn)
    $past(use_ps && direct[0] && !src_bad) |-> pair0_out_a == $past(src_lvl);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path not copying source");

  // Direct routing on pair 1 drives both legs from the source.
  property p_direct_pair;
    @(posedge clk) disable iff (!resetn)
    $past(use_ps && direct[1] && !src_bad) |-> pair1_out_b == !$past(src_lvl);
  endproperty
  a_direct_pair: assert property (p_direct_pair) else $error("direct complement wrong");

  // A forbidden source code holds the true legs of pairs 0, 2 and 4 low.
  property p_bad_source;
    @(posedge clk) disable iff (!resetn)
    $past(src_bad) |-> !pair0_out_a && !pair2_out_a && !pair4_out_a;
  endproperty
  a_bad_source: assert property (p_bad_source) else $error("outputs run on bad source");

  // With code 10b the prescaler only advances on oscillator rising edges.
  property p_osc_source;
    @(posedge clk) disable iff (!resetn)
    ($changed(ps_cnt_r) && $past(src_code == cdd_pkg::SRC_OSC_PS))
      |-> $past(osc_clk_in && !src_prev_r);
  endproperty
  a_osc_source: assert property (p_osc_source) else $error("prescaler not on oscillator");

  // With code 00b the prescaler only advances on external rising edges.
  property p_ext_source;
    @(posedge clk) disable iff (!resetn)
    ($changed(ps_cnt_r) && $past(src_code == cdd_pkg::SRC_EXT_PS))
      |-> $past(ext_clk_in && !src_prev_r);
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("prescaler not on external");

  // The prescaler counter wraps after ratio rising edges.
  property p_presc_wrap;
    @(posedge clk) disable iff (!resetn)
    $past(use_ps && src_rise && (ps_cnt_r == ps_ratio - 3'h1)) |-> ps_cnt_r == 3'h0;
  endproperty
  a_presc_wrap: assert property (p_presc_wrap) else $error("prescaler ratio wrong");

  // Without the prescaler its counters stand still.
  property p_presc_idle;
    @(posedge clk) disable iff (!resetn)
    $past(src_code == cdd_pkg::SRC_EXT_DIRECT) |-> !$changed(ps_cnt_r) && !$changed(ps_edge_r);
  endproperty
  a_presc_idle: assert property (p_presc_idle) else $error("prescaler runs while skipped");

endmodule

`default_nettype wire

// ===== cdd_pkg.sv
// Package with register offsets, field positions and codes of the clock distribution dividers.
package cdd_pkg;

  // Register bus widths.
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [9:0] OFS_CH0_COUNTS = 10'h190;
  localparam logic [9:0] OFS_CH0_BYPASS = 10'h191;
  localparam logic [9:0] OFS_CH0_ROUTE = 10'h192;
  localparam logic [9:0] OFS_CH1_COUNTS = 10'h193;
  localparam logic [9:0] OFS_CH1_BYPASS = 10'h194;
  localparam logic [9:0] OFS_CH1_ROUTE = 10'h195;
  localparam logic [9:0] OFS_CH2_COUNTS = 10'h196;
  localparam logic [9:0] OFS_CH2_BYPASS = 10'h197;
  localparam logic [9:0] OFS_CH2_ROUTE = 10'h198;
  localparam logic [9:0] OFS_CH3_S1_COUNTS = 10'h199;
  localparam logic [9:0] OFS_CH3_S2_COUNTS = 10'h19b;
  localparam logic [9:0] OFS_CH3_BYPASS = 10'h19c;
  localparam logic [9:0] OFS_CH3_DUTY = 10'h19d;
  localparam logic [9:0] OFS_CH4_S1_COUNTS = 10'h19e;
  localparam logic [9:0] OFS_CH4_S2_COUNTS = 10'h1a0;
  localparam logic [9:0] OFS_CH4_BYPASS = 10'h1a1;
  localparam logic [9:0] OFS_CH4_DUTY = 10'h1a2;
  localparam logic [9:0] OFS_PRESCALER = 10'h1e0;
  localparam logic [9:0] OFS_SOURCE = 10'h1e1;
  localparam logic [9:0] OFS_STATUS = 10'h1e2;

  // Storage indices; single channels take three entries each, cascaded ones four.
  localparam int NREG = 19;
  localparam int IDX_CH0_COUNTS = 0;
  localparam int SINGLE_STRIDE = 3;
  localparam int IDX_PRESCALER = 9;
  localparam int IDX_SOURCE = 10;
  localparam int IDX_CH3_S1 = 11;
  localparam int CASC_STRIDE = 4;

  // Field positions.
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int HIGH_LSB = 0;
  localparam int BIT_BYPASS = 7;
  localparam int BIT_DIRECT = 1;
  localparam int BIT_DUTY_OFF = 0;
  localparam int BIT_BYP_S1 = 4;
  localparam int BIT_BYP_S2 = 5;
  localparam int STAT_SRC_BAD = 5;
  localparam int STAT_USE_PS = 6;

  // Source select codes.
  localparam logic [1:0] SRC_EXT_PS = 2'h0;
  localparam logic [1:0] SRC_EXT_DIRECT = 2'h1;
  localparam logic [1:0] SRC_OSC_PS = 2'h2;
  localparam logic [1:0] SRC_BAD = 2'h3;

  // Prescaler ratio limits and reset values.
  localparam logic [2:0] PRESC_MIN = 3'h2;
  localparam logic [2:0] PRESC_MAX = 3'h6;
  localparam logic [7:0] RST_PRESCALER = 8'h02;
  localparam logic [7:0] RST_SOURCE = 8'h02;
  localparam logic [7:0] RST_OTHER = 8'h00;

endpackage

// ===== cdd_clock_dividers_test.sv
// Self-checking testbench for the clock distribution dividers.
`timescale 1ns/1ps
`default_nettype none

module cdd_clock_dividers_test;
  // One row: source code, prescaler, counts, bypass, route byte, channel, period, high time.
  typedef struct {
    logic [1:0] src;
    logic [7:0] ps;
    logic [7:0] cnt;
    logic [7:0] byp;
    logic [7:0] route;
    int ch;
    int per;
    int hi;
  } cdd_row_t;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_clk_in = 1'b0;
  logic osc_clk_in = 1'b0;
  logic [4:0] pa;
  logic [4:0] pb;
  int osc_cnt = 0;
  int ext_cnt = 0;
  int miscompares = 0;
  int checks_done = 0;
  // Periods in clk cycles: oscillator 4 (2 high), external 8 (3 high).
  cdd_row_t rows [14] = '{
    '{2'h2, 8'h02, 8'h00, 8'h00, 8'h01, 0, 16, 8},
    '{2'h2, 8'h03, 8'h00, 8'h00, 8'h01, 1, 24, 12},
    '{2'h2, 8'h06, 8'h21, 8'h00, 8'h01, 2, 120, 48},
    '{2'h2, 8'h05, 8'hff, 8'h00, 8'h01, 0, 640, 320},
    '{2'h2, 8'h03, 8'h00, 8'h80, 8'h01, 0, 12, 4},
    '{2'h2, 8'h05, 8'h00, 8'h80, 8'h01, 1, 20, 8},
    '{2'h2, 8'h05, 8'h00, 8'h80, 8'h00, 2, 20, 10},
    '{2'h2, 8'h04, 8'h00, 8'h00, 8'h02, 0, 4, 2},
    '{2'h0, 8'h04, 8'h00, 8'h00, 8'h03, 1, 8, 3},
    '{2'h0, 8'h02, 8'h00, 8'h00, 8'h01, 2, 32, 16},
    '{2'h1, 8'h02, 8'h00, 8'h80, 8'h01, 0, 8, 3},
    '{2'h1, 8'h02, 8'h11, 8'h00, 8'h01, 1, 32, 16},
    '{2'h1, 8'h02, 8'h00, 8'h00, 8'h02, 2, 16, 8},
    '{2'h2, 8'h02, 8'h10, 8'h00, 8'h00, 0, 24, 12}
  };

  logic pair0_out_a, pair0_out_b, pair1_out_a, pair1_out_b, pair2_out_a, pair2_out_b;
  logic pair3_out_a, pair3_out_b, pair4_out_a, pair4_out_b;

  // Output legs gathered by pair number.
  assign pa = {pair4_out_a, pair3_out_a, pair2_out_a, pair1_out_a, pair0_out_a};
  assign pb = {pair4_out_b, pair3_out_b, pair2_out_b, pair1_out_b, pair0_out_b};

  cdd_clock_dividers i_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in),
    .pair0_out_a(pair0_out_a), .pair0_out_b(pair0_out_b),
    .pair1_out_a(pair1_out_a), .pair1_out_b(pair1_out_b),
    .pair2_out_a(pair2_out_a), .pair2_out_b(pair2_out_b),
    .pair3_out_a(pair3_out_a), .pair3_out_b(pair3_out_b),
    .pair4_out_a(pair4_out_a), .pair4_out_b(pair4_out_b)
  );

  // The 4 ns system clock.
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Source clocks run free: oscillator at 50%, external at 3 of 8 cycles high.
  always @(posedge clk)
  begin
    osc_cnt <= (osc_cnt + 1) % 4;
    ext_cnt <= (ext_cnt + 1) % 8;
    osc_clk_in <= (osc_cnt < 1) || (osc_cnt == 3);
    ext_clk_in <= (ext_cnt < 2) || (ext_cnt == 7);
  end

  task automatic results;
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkn(input string nm, input int e, input int g);
    checks_done++;
    if (g != e)
    begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data are taken in the cycle after the read edge.
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Reads every register of channels 0 to 2, the prescaler, source and one unmapped place.
  task automatic defaults;
    logic [7:0] d;
    for (int i = 0; i < 9; i++)
    begin
      rd(cdd_pkg::OFS_CH0_COUNTS + 10'(i), d);
      chk8("reset_value", cdd_pkg::RST_OTHER, d);
    end
    rd(cdd_pkg::OFS_PRESCALER, d);
    chk8("prescaler_reset", cdd_pkg::RST_PRESCALER, d);
    rd(cdd_pkg::OFS_SOURCE, d);
    chk8("source_reset", cdd_pkg::RST_SOURCE, d);
    rd(10'h1ff, d);
    chk8("unmapped", 8'h00, d);
  endtask

  // Syncs to a rising edge of pair ch, then measures two periods and keeps the last.
  task automatic meas(input int ch, output int per, output int hi);
    int n;
    int bad;
    logic last;
    n = 0;
    bad = 0;
    while (pa[ch] !== 1'b0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    while (pa[ch] !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2)
    begin
      per = 0;
      hi = 0;
      last = 1'b1;
      while (!(last === 1'b0 && pa[ch] === 1'b1) && per < 4000)
      begin
        if (pa[ch] === 1'b1) hi++;
        if (pb[ch] !== ~pa[ch]) bad++;
        last = pa[ch];
        @(negedge clk);
        per++;
      end
    end
    chkn("complement_leg", 0, bad);
  endtask

  // Watchdog at several times the expected run length of about 3500 cycles.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    int per;
    int hi;
    logic [7:0] d;
    logic [9:0] base;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    defaults();
    // Row table of divider configurations.
    foreach (rows[i])
    begin
      base = cdd_pkg::OFS_CH0_COUNTS + 10'(3 * rows[i].ch);
      wr(cdd_pkg::OFS_SOURCE, {6'h00, rows[i].src});
      wr(cdd_pkg::OFS_PRESCALER, rows[i].ps);
      wr(base, rows[i].cnt);
      wr(base + 10'h001, rows[i].byp);
      wr(base + 10'h002, rows[i].route);
      meas(rows[i].ch, per, hi);
      chkn("period", rows[i].per, per);
      chkn("high_time", rows[i].hi, hi);
    end
    // Cascaded channel: stage 1 divides by 3, stage 2 by 2, correction off.
    wr(cdd_pkg::OFS_SOURCE, 8'h02);
    wr(cdd_pkg::OFS_PRESCALER, 8'h02);
    wr(cdd_pkg::OFS_CH3_S1_COUNTS, 8'h10);
    wr(cdd_pkg::OFS_CH3_S2_COUNTS, 8'h00);
    wr(cdd_pkg::OFS_CH3_BYPASS, 8'h00);
    wr(cdd_pkg::OFS_CH3_DUTY, 8'h01);
    meas(3, per, hi);
    chkn("cascade_period", 48, per);
    chkn("cascade_high", 24, hi);
    // Channel 4 with both stages bypassed and correction on: ratio 3, corrected to 50%.
    wr(cdd_pkg::OFS_PRESCALER, 8'h03);
    wr(cdd_pkg::OFS_CH4_BYPASS, 8'h30);
    meas(4, per, hi);
    chkn("cascade_bypass_period", 12, per);
    chkn("cascade_bypass_high", 6, hi);
    // Full bytes read back; unmapped writes are dropped.
    wr(cdd_pkg::OFS_CH1_BYPASS, 8'ha5);
    wr(10'h1ff, 8'hff);
    rd(cdd_pkg::OFS_CH1_BYPASS, d);
    chk8("readback", 8'ha5, d);
    rd(10'h1ff, d);
    chk8("unmapped_write", 8'h00, d);
    // Code 11b holds every true leg low and every complement high.
    wr(cdd_pkg::OFS_SOURCE, 8'h03);
    repeat (20) @(negedge clk);
    repeat (10)
    begin
      @(negedge clk);
      chk8("forbidden_a", 8'h00, {3'h0, pa});
      chk8("forbidden_b", 8'h1f, {3'h0, pb});
    end
    // Status shows the forbidden code, no prescaler and all true legs low.
    rd(cdd_pkg::OFS_STATUS, d);
    chk8("status_forbidden", 8'h20, d);
    // Mid-run reset restores defaults.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(negedge clk);
    chk8("reset_legs", 8'h1f, {3'h0, pb});
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    defaults();
    // Correction on after reset; disabling it on channel 1 leaves channel 0 corrected.
    wr(cdd_pkg::OFS_CH0_COUNTS, 8'h10);
    wr(cdd_pkg::OFS_CH1_COUNTS, 8'h10);
    wr(cdd_pkg::OFS_CH1_ROUTE, 8'h01);
    meas(0, per, hi);
    chkn("dcc_on_high", 12, hi);
    meas(1, per, hi);
    chkn("dcc_off_high", 8, hi);
    chkn("dcc_off_period", 24, per);
    results();
  end
endmodule

`default_nettype wire
